// [rtl/xbsel_defs.svh]
// constants for the sub-bus select and buffer control block
// assumes: included by its bare name from the package and the rtl modules
`ifndef XBSEL_DEFS_SVH
`define XBSEL_DEFS_SVH

// ----------------------------------------------------------------
// address layout: la[23:17] over sa[16:0]
// ----------------------------------------------------------------
`define XBSEL_ADR_W 24
`define XBSEL_LA_MSB 23
`define XBSEL_LA_LSB 17
`define XBSEL_IO_MSB 15

// boot rom windows, compared on the la field
`define XBSEL_ROM_LA_LOW 7'h07
`define XBSEL_ROM_LA_HIGH 7'h7F
// optional interrupt-controller memory window, la field
`define XBSEL_INTC_LA 7'h7E

// ----------------------------------------------------------------
// fixed i/o ports
// ----------------------------------------------------------------
`define XBSEL_KBC_DATA 16'h0060
`define XBSEL_KBC_CMD 16'h0064
`define XBSEL_RTC_INDEX 16'h0070
`define XBSEL_RTC_DATA 16'h0071

// ----------------------------------------------------------------
// select enable bits
// ----------------------------------------------------------------
`define XBSEL_EN_W 4
`define XBSEL_EN_ROM 0
`define XBSEL_EN_KBC 1
`define XBSEL_EN_RTC 2
`define XBSEL_EN_INTC 3

// ----------------------------------------------------------------
// programmable range: base[15:2] in bits 15:2, size code in 17:16
// ----------------------------------------------------------------
`define XBSEL_PRG_W 18
`define XBSEL_PRG_BASE_MSB 15
`define XBSEL_PRG_BASE_LSB 2
`define XBSEL_PRG_SIZE_MSB 17
`define XBSEL_PRG_SIZE_LSB 16
`define XBSEL_PRG_SZ4 2'h0
`define XBSEL_PRG_SZ8 2'h1
`define XBSEL_PRG_SZ16 2'h2

// ----------------------------------------------------------------
// command bit order and latch strobe timing
// ----------------------------------------------------------------
`define XBSEL_CMD_W 4
`define XBSEL_CMD_IOR 0
`define XBSEL_CMD_IOW 1
`define XBSEL_CMD_MEMR 2
`define XBSEL_CMD_MEMW 3
`define XBSEL_ALE_SYSCLKS 2
`define XBSEL_CNT_W 4

`endif

// [rtl/xbsel_pkg.sv]
// types shared by the sub-bus select and buffer control modules
// assumes: xbsel_defs.svh is reachable on the include path
`include "xbsel_defs.svh"

package xbsel_pkg;

    // address latch strobe sequencer, one-hot
    typedef enum logic [1:0] {
        XBSEL_ALE_IDLE = 2'b01,
        XBSEL_ALE_HOLD = 2'b10
    } xbsel_ale_e;

    // whole state of the control module
    typedef struct packed {
        logic [`XBSEL_CMD_W-1:0] cmd_s1;  // command pins, first stage
        logic [`XBSEL_CMD_W-1:0] cmd_s2;  // command pins, second stage
        logic [`XBSEL_CMD_W-1:0] cmd_d;   // delayed copy for edges
        logic [`XBSEL_ADR_W-1:0] adr_s1;
        logic [`XBSEL_ADR_W-1:0] adr_s2;
        logic [`XBSEL_ADR_W-1:0] adr_hold; // address of an isa master cycle
        logic aen_s1;
        logic aen_s2;
        logic dack_s1;
        logic dack_s2;
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_d;
        logic isa_hold;                    // output enable held for isa master
        xbsel_ale_e ale_st;
        logic [`XBSEL_CNT_W-1:0] ale_cnt;
        logic dir_n;
        logic oe_n;
        logic prg_n;
        logic rom_n;
        logic kbc_n;
        logic rtc_n;
        logic ale;
    } xbsel_state_s;

endpackage

// [rtl/xbsel_dec_if.sv]
// carrier between the control module and its address decoder
// assumes: one clock domain, decoder is purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "xbsel_defs.svh"

interface xbsel_dec_if;
    logic [`XBSEL_ADR_W-1:0] adr;      // synchronised address
    logic [`XBSEL_PRG_W-1:0] prg;      // programmable range setting
    logic rom_hit;
    logic intc_hit;
    logic kbc_hit;
    logic rtc_idx_hit;
    logic rtc_dat_hit;
    logic prg_hit;

    modport ctl (output adr, output prg, input rom_hit, input intc_hit,
        input kbc_hit, input rtc_idx_hit, input rtc_dat_hit, input prg_hit);
    modport dec (input adr, input prg, output rom_hit, output intc_hit,
        output kbc_hit, output rtc_idx_hit, output rtc_dat_hit, output prg_hit);
endinterface

`default_nettype wire

// [rtl/xbsel_decode.sv]
// address decoder for the sub-bus peripherals
// assumes: address already synchronised by the caller
`timescale 1ns/1ps
`default_nettype none
`include "xbsel_defs.svh"

module xbsel_decode
    import xbsel_pkg::*;
(
    xbsel_dec_if.dec dif
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic [6:0] la;                     // upper address field
    logic [15:0] io;                    // i/o port address
    logic [15:0] pmask;                 // low bits ignored by range compare
    logic [15:0] pbase;

    // fixed windows and programmable range compare
    always_comb begin
        la = dif.adr[`XBSEL_LA_MSB:`XBSEL_LA_LSB];
        io = dif.adr[`XBSEL_IO_MSB:0];
        pbase = {dif.prg[`XBSEL_PRG_BASE_MSB:`XBSEL_PRG_BASE_LSB], 2'h0};
        unique case (dif.prg[`XBSEL_PRG_SIZE_MSB:`XBSEL_PRG_SIZE_LSB])
            `XBSEL_PRG_SZ4: pmask = 16'hFFFC;
            `XBSEL_PRG_SZ8: pmask = 16'hFFF8;
            `XBSEL_PRG_SZ16: pmask = 16'hFFF0;
            default: pmask = 16'h0000; // size code 3: range off
        endcase
        dif.rom_hit = (la == `XBSEL_ROM_LA_LOW) || (la == `XBSEL_ROM_LA_HIGH);
        dif.intc_hit = (la == `XBSEL_INTC_LA);
        dif.kbc_hit = (io == `XBSEL_KBC_DATA) || (io == `XBSEL_KBC_CMD);
        dif.rtc_idx_hit = (io == `XBSEL_RTC_INDEX);
        dif.rtc_dat_hit = (io == `XBSEL_RTC_DATA);
        // a zero mask means disabled, so never match
        dif.prg_hit = (pmask != 16'h0000) && ((io & pmask) == (pbase & pmask));
    end

endmodule

`default_nettype wire

// [rtl/xbsel_ctrl.sv]
// sub-bus chip select and data transceiver control, top module
// assumes: isa commands, address, aen, dack and sysclk arrive from pins;
// cycle-source flags and enables come from logic on clk
//
// each output trails its pin cause by three clk cycles
// command pulses under one clk cycle may be missed
// the address must stand still around a command edge,
// as it is synchronised bit by bit and could tear
// cycle-source flags are trusted as clk-domain levels
// sysclk is only sampled and counted, never used as a clock
`timescale 1ns/1ps
`default_nettype none
`include "xbsel_defs.svh"

module xbsel_ctrl
    import xbsel_pkg::*;
#(
    parameter int ALE_SYSCLKS = `XBSEL_ALE_SYSCLKS, // latch strobe length
    parameter bit HAS_INTC_SPACE = 1'b0             // intc memory window option
)
(
    input wire logic clk,
    input wire logic reset_n,

    // isa side pins, asynchronous to clk
    input wire logic ior_n,
    input wire logic iow_n,
    input wire logic memr_n,
    input wire logic memw_n,
    input wire logic [16:0] sa,
    input wire logic [23:17] la,
    input wire logic aen,
    input wire logic dack_n,
    input wire logic sysclk,

    // cycle source, from bridge logic on clk
    input wire logic pci_cycle,
    input wire logic isa_master_cycle,
    input wire logic subtractive_isa,
    input wire logic dma_xbus_read,

    // configuration, from logic on clk
    input wire logic [`XBSEL_EN_W-1:0] xbus_select_enable_reg,
    input wire logic [`XBSEL_PRG_W-1:0] prog_select_range_reg,

    // sub-bus outputs
    output logic xbus_direction_n,
    output logic xbus_output_enable_n,
    output logic programmable_select_n,
    output logic boot_rom_select_n,
    output logic keyboard_ctrl_select_n,
    output logic clock_chip_select_n,
    output logic clock_chip_addr_latch
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // the strobe counter is a fixed field of the state struct
    // and a strobe of no sysclks could never be seen
    if (ALE_SYSCLKS < 1 || ALE_SYSCLKS > 15) begin : g_bad_ale
        $error("ALE_SYSCLKS must lie in 1..15");
    end

    // last count before the strobe drops
    localparam logic [`XBSEL_CNT_W-1:0] ALE_LAST = (`XBSEL_CNT_W)'(ALE_SYSCLKS - 1);

    // ----------------------------------------------------------------
    // state and decoder
    // ----------------------------------------------------------------
    xbsel_state_s cur_ff;   // registered state
    xbsel_state_s nxt_st;   // next state
    xbsel_dec_if dif ();    // carrier to the decoder

    // the decoder is pure logic on the synchronised address
    xbsel_decode u_dec (
        .dif(dif.dec)
    );

    // decoder works on the synchronised address only
    assign dif.adr = cur_ff.adr_s2;
    // the range setting is already on clk and needs no flops
    assign dif.prg = prog_select_range_reg;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    // working values, all set on every pass of the next-state process
    logic [`XBSEL_CMD_W-1:0] cmd_low;   // command asserted
    logic [`XBSEL_CMD_W-1:0] cmd_fall;  // command just asserted
    logic any_low;
    logic any_fall;

    logic dma;                          // dma owns the bus
    logic sclk_rise;
    logic io_cmd;

    logic mem_rd_dir;
    logic hit_en;                       // enabled peripheral decoded
    logic prg_sel;
    logic oe_cmd;

    // one process computes the whole next state
    always_comb begin
        nxt_st = cur_ff;

        // two-flop synchronisers; stage one feeds stage two only
        // stage one may be metastable, so no decode reads it
        nxt_st.cmd_s1 = {memw_n, memr_n, iow_n, ior_n};
        nxt_st.cmd_s2 = cur_ff.cmd_s1;
        nxt_st.cmd_d = cur_ff.cmd_s2;

        nxt_st.adr_s1 = {la, sa};
        nxt_st.adr_s2 = cur_ff.adr_s1;

        nxt_st.aen_s1 = aen;
        nxt_st.aen_s2 = cur_ff.aen_s1;

        nxt_st.dack_s1 = dack_n;
        nxt_st.dack_s2 = cur_ff.dack_s1;

        nxt_st.sclk_s1 = sysclk;
        nxt_st.sclk_s2 = cur_ff.sclk_s1;
        nxt_st.sclk_d = cur_ff.sclk_s2;

        // edges are taken from stage two and its delayed copy
        // aen high marks a dma cycle, which owns the address
        cmd_low = ~cur_ff.cmd_s2;
        cmd_fall = cur_ff.cmd_d & ~cur_ff.cmd_s2;
        any_low = |cmd_low;
        any_fall = |cmd_fall;

        dma = cur_ff.aen_s2;
        sclk_rise = cur_ff.sclk_s2 & ~cur_ff.sclk_d;

        io_cmd = cmd_low[`XBSEL_CMD_IOR] | cmd_low[`XBSEL_CMD_IOW];

        // --- transceiver direction ---
        // low points the transceiver toward the system data bus
        // an i/o read turns it even for a target off the sub-bus
        // memory read decode
        // pci may also hit intc window
        mem_rd_dir = cmd_low[`XBSEL_CMD_MEMR] & ~dma
            & (dif.rom_hit | (HAS_INTC_SPACE & pci_cycle & dif.intc_hit));

        nxt_st.dir_n = ~((cmd_low[`XBSEL_CMD_IOR] & ~dma) | mem_rd_dir
            | (~cur_ff.dack_s2 & dma_xbus_read));

        // --- programmable select ---
        // cycle flags are clk-domain levels, stable through the cycle
        // a programmable hit also opens the transceiver below
        // subtractive pci i/o in range
        prg_sel = pci_cycle & subtractive_isa & io_cmd & ~dma & dif.prg_hit;
        nxt_st.prg_n = ~prg_sel;

        // --- output enable ---
        // cpu and pci cycles release with the command; isa masters
        // hold it until the address moves, as their data may linger
        // enabled peripheral decode only
        hit_en = (dif.rom_hit & xbus_select_enable_reg[`XBSEL_EN_ROM])
            | (dif.kbc_hit & io_cmd & xbus_select_enable_reg[`XBSEL_EN_KBC])
            | ((dif.rtc_idx_hit | dif.rtc_dat_hit) & io_cmd
                & xbus_select_enable_reg[`XBSEL_EN_RTC])
            | (HAS_INTC_SPACE & pci_cycle & dif.intc_hit
                & xbus_select_enable_reg[`XBSEL_EN_INTC])
            | prg_sel;

        // cpu/pci: active while the command is low
        oe_cmd = ~isa_master_cycle & any_low & ~dma & hit_en;

        // isa master: caught at the command fall
        if (isa_master_cycle && any_fall && !dma && hit_en) begin
            nxt_st.isa_hold = 1'b1;
            // remember the address; any change ends the hold
            nxt_st.adr_hold = cur_ff.adr_s2;
        end else if (cur_ff.isa_hold && (cur_ff.adr_s2 != cur_ff.adr_hold)) begin
            // isa master released on address change
            nxt_st.isa_hold = 1'b0;
        end
        nxt_st.oe_n = ~(oe_cmd | nxt_st.isa_hold);

        // --- fixed chip selects ---
        // enable bits gate only the transceiver, never a select
        // dma drives its own address, which must not open the rom
        // rom decode from address lines
        nxt_st.rom_n = ~(dif.rom_hit & ~dma);

        nxt_st.kbc_n = ~(dif.kbc_hit & io_cmd & ~dma);

        // the index port has no select; the latch strobe serves it
        // clock chip data port
        nxt_st.rtc_n = ~(dif.rtc_dat_hit & io_cmd & ~dma);

        // --- address latch strobe ---
        // counted in synchronised sysclk rises, so the length may be
        // short of the ideal by up to one sysclk period, but never beyond it
        unique case (cur_ff.ale_st)
            XBSEL_ALE_IDLE: begin
                if (cmd_fall[`XBSEL_CMD_IOW] && dif.rtc_idx_hit && !dma) begin
                    nxt_st.ale_st = XBSEL_ALE_HOLD;
                    nxt_st.ale_cnt = '0;
                    nxt_st.ale = 1'b1;
                end
            end
            XBSEL_ALE_HOLD: begin
                if (sclk_rise) begin
                    if (cur_ff.ale_cnt == ALE_LAST) begin
                        // last counted rise drops the strobe
                        nxt_st.ale_st = XBSEL_ALE_IDLE;
                        nxt_st.ale = 1'b0;
                    end else begin
                        nxt_st.ale_cnt = cur_ff.ale_cnt + 1'b1;
                    end
                end
            end
            default: begin
                // illegal code: recover to idle, strobe off
                nxt_st.ale_st = XBSEL_ALE_IDLE;
                nxt_st.ale = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // synchronous reset; commands and acknowledge reset idle-high so the
    // first edge after release is not mistaken for a falling command
    // the state code resets to idle, the active-low outputs high, the rest to zero: strobe off, hold clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cur_ff <= '0;
            cur_ff.cmd_s1 <= '1;
            cur_ff.cmd_s2 <= '1;
            cur_ff.cmd_d <= '1;

            cur_ff.dack_s1 <= 1'b1;
            cur_ff.dack_s2 <= 1'b1;
            cur_ff.ale_st <= XBSEL_ALE_IDLE;
            // outputs parked inactive
            cur_ff.dir_n <= 1'b1;
            cur_ff.oe_n <= 1'b1;
            cur_ff.prg_n <= 1'b1;
            cur_ff.rom_n <= 1'b1;
            cur_ff.kbc_n <= 1'b1;
            cur_ff.rtc_n <= 1'b1;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from flops
    // ----------------------------------------------------------------
    // no output can glitch while the address settles
    assign xbus_direction_n = cur_ff.dir_n;
    assign xbus_output_enable_n = cur_ff.oe_n;

    assign programmable_select_n = cur_ff.prg_n;
    assign boot_rom_select_n = cur_ff.rom_n;
    assign keyboard_ctrl_select_n = cur_ff.kbc_n;
    assign clock_chip_select_n = cur_ff.rtc_n;

    assign clock_chip_addr_latch = cur_ff.ale;

endmodule

`default_nettype wire

// [verif/xbsel_ctrl_chk.sv]
// assertion checker for the sub-bus select and buffer control block
// assumes: bound to xbsel_ctrl, pins idle while reset is held, sysclk of 30 clk
`timescale 1ns/1ps
`default_nettype none
`include "xbsel_defs.svh"

module xbsel_ctrl_chk #(
    parameter int ALE_SYSCLKS = 2
)(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ior_n,
    input wire logic iow_n,
    input wire logic memr_n,
    input wire logic [16:0] sa,
    input wire logic [23:17] la,
    input wire logic aen,
    input wire logic dack_n,
    input wire logic dma_xbus_read,
    input wire logic xbus_direction_n,
    input wire logic xbus_output_enable_n,
    input wire logic programmable_select_n,
    input wire logic boot_rom_select_n,
    input wire logic keyboard_ctrl_select_n,
    input wire logic clock_chip_select_n,
    input wire logic clock_chip_addr_latch
);
    // ------------------------------------------------------------
    // helper decode, three-cycle pin lag
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [2:0] up_ff; // cycles since reset, so $past never reaches into it
    logic ok, io_c, rom_a, kbc_c, rtc_c, ale_c, dir_c;
    assign ok = up_ff == 3'h7;
    assign io_c = (!ior_n || !iow_n) && !aen;
    assign rom_a = la == `XBSEL_ROM_LA_LOW || la == `XBSEL_ROM_LA_HIGH;
    assign kbc_c = io_c && (sa[15:0] == `XBSEL_KBC_DATA || sa[15:0] == `XBSEL_KBC_CMD);
    assign rtc_c = io_c && sa[15:0] == `XBSEL_RTC_DATA;
    assign ale_c = !iow_n && !aen && sa[15:0] == `XBSEL_RTC_INDEX;
    assign dir_c = (!ior_n && !aen) || (!memr_n && rom_a) || (!dack_n && dma_xbus_read);

    // saturating count after each release of reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            up_ff <= 3'h0;
        end else if (!ok) begin
            up_ff <= up_ff + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0) !reset_n |=>
        {xbus_direction_n, xbus_output_enable_n, programmable_select_n, boot_rom_select_n,
        keyboard_ctrl_select_n, clock_chip_select_n, clock_chip_addr_latch} == 7'h7E)
        else $error("outputs active after reset");
    a_rom_decode: assert property (ok |-> boot_rom_select_n == !$past(rom_a && !aen, 3))
        else $error("rom select wrong");
    a_kbc_decode: assert property (ok |-> keyboard_ctrl_select_n == !$past(kbc_c, 3))
        else $error("keyboard select wrong");
    a_rtc_decode: assert property (ok |-> clock_chip_select_n == !$past(rtc_c, 3))
        else $error("clock chip select wrong");
    a_dir_io_read: assert property (ok && $past(!ior_n && !aen, 3) |-> !xbus_direction_n)
        else $error("direction missing on io read");
    a_dir_cause: assert property (ok && !xbus_direction_n |-> $past(dir_c, 3))
        else $error("direction without cause");
    a_ale_start: assert property ($rose(clock_chip_addr_latch) |-> $past(ale_c, 3))
        else $error("latch without index write");
    a_ale_hold: assert property ($rose(clock_chip_addr_latch) |-> clock_chip_addr_latch[*8])
        else $error("latch too short");
    // two sysclk periods of 30 clk plus sync lag end inside this window
    a_ale_ends: assert property ($rose(clock_chip_addr_latch) |-> ##[28:70] !clock_chip_addr_latch)
        else $error("latch too long");
    a_prg_oe: assert property (!programmable_select_n |-> !xbus_output_enable_n)
        else $error("programmable select without transceiver");

    c_latch: cover property (!clock_chip_addr_latch ##1 clock_chip_addr_latch);
    c_prg: cover property (!programmable_select_n);
    c_dma_read: cover property (!xbus_direction_n && !dack_n);
endmodule

bind xbsel_ctrl xbsel_ctrl_chk #(.ALE_SYSCLKS(ALE_SYSCLKS)) xbsel_ctrl_chk_inst (.clk, .reset_n,
    .ior_n, .iow_n, .memr_n, .sa, .la, .aen, .dack_n, .dma_xbus_read, .xbus_direction_n,
    .xbus_output_enable_n, .programmable_select_n, .boot_rom_select_n, .keyboard_ctrl_select_n,
    .clock_chip_select_n, .clock_chip_addr_latch);
`default_nettype wire

// [verif/xbsel_xbus_model.sv]
// behavioural sub-bus: data transceiver, keyboard and clock chips
// assumes: selects and transceiver controls come straight from the block
`timescale 1ns/1ps
`default_nettype none

module xbsel_xbus_model #(
    parameter int DELAY_NS = 3,             // larger values give a slow peripheral
    parameter logic [7:0] KBC_DATA = 8'hA5  // keyboard read value
)(
    input wire logic dir_n,
    input wire logic oe_n,
    input wire logic kbc_n,
    input wire logic rtc_n,
    input wire logic ale,
    input wire logic [7:0] sd_wr,
    output logic [7:0] sd_rd
);
    logic [7:0] idx = 8'h00;  // clock chip index
    logic [7:0] last = 8'h00; // last value driven onto system data
    logic drv;
    logic [7:0] val;

    // index taken when the strobe closes, so a short strobe still latches
    always @(negedge ale) begin
        idx = sd_wr;
    end

    // data reaches the system only through an enabled, inward transceiver
    assign drv = !dir_n && !oe_n && (!rtc_n || !kbc_n);
    // clock chip contents modelled as the inverted index
    assign val = !rtc_n ? ~idx : KBC_DATA;

    always @(drv or val) begin
        if (drv) begin
            last = val;
        end
    end

    // released bus shows the inverse of the last value, never a stale copy
    assign #DELAY_NS sd_rd = drv ? val : ~last;
endmodule
`default_nettype wire

// [verif/xbus_select_buffer_ctrl_test.sv]
// self-checking bench for the sub-bus select and buffer control block
// assumes: rtl, checker and sub-bus model compiled before this file
`timescale 1ns/1ps
`default_nettype none
`include "xbsel_defs.svh"

module xbus_select_buffer_ctrl_test;
    import xbsel_pkg::*;
    localparam int SYSP = 30; // sysclk period in clk cycles
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic sysclk = 1'h0;
    logic [3:0] cmd_n = 4'hF; // ior, iow, memr, memw
    logic [16:0] sa = 17'h00000;
    logic [23:17] la = 7'h00;
    logic aen = 1'h0;
    logic dack_n = 1'h1;
    logic pci_cycle = 1'h1;
    logic isa_cycle = 1'h0;
    logic sub_isa = 1'h0;
    logic dma_rd = 1'h0;
    logic [3:0] en = 4'h7;
    logic [17:0] prg = 18'h30000; // size code 3, range off
    logic dir_n, oe_n, prg_n, rom_n, kbc_n, rtc_n, ale;
    logic [7:0] sd_wr = 8'h00;
    logic [7:0] sd_rd;
    logic [7:0] last_rd;
    logic [7:0] outs; // bits: 6 dir, 5 oe, 4 prg, 3 rom, 2 kbc, 1 rtc, 0 latch
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    assign outs = {1'h0, dir_n, oe_n, prg_n, rom_n, kbc_n, rtc_n, ale};

    // ------------------------------------------------------------
    // clocks and instances
    // ------------------------------------------------------------
    always #2 clk = ~clk;
    always #60 sysclk = ~sysclk;

    xbsel_ctrl #(.ALE_SYSCLKS(2)) xbsel_ctrl_inst (.clk(clk), .reset_n(reset_n),
        .ior_n(cmd_n[`XBSEL_CMD_IOR]), .iow_n(cmd_n[`XBSEL_CMD_IOW]),
        .memr_n(cmd_n[`XBSEL_CMD_MEMR]), .memw_n(cmd_n[`XBSEL_CMD_MEMW]), .sa(sa), .la(la),
        .aen(aen), .dack_n(dack_n), .sysclk(sysclk), .pci_cycle(pci_cycle),
        .isa_master_cycle(isa_cycle), .subtractive_isa(sub_isa), .dma_xbus_read(dma_rd),
        .xbus_select_enable_reg(en), .prog_select_range_reg(prg), .xbus_direction_n(dir_n),
        .xbus_output_enable_n(oe_n), .programmable_select_n(prg_n),
        .boot_rom_select_n(rom_n), .keyboard_ctrl_select_n(kbc_n),
        .clock_chip_select_n(rtc_n), .clock_chip_addr_latch(ale));

    xbsel_xbus_model xbsel_xbus_model_inst (.dir_n(dir_n), .oe_n(oe_n), .kbc_n(kbc_n),
        .rtc_n(rtc_n), .ale(ale), .sd_wr(sd_wr), .sd_rd(sd_rd));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    // inputs always move 1 ns after the edge, clear of sampling
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    // one command cycle; six clocks cover the three-clock pin lag
    task automatic op(input int b, input logic [23:0] a, input logic [7:0] e_on,
        input logic [7:0] e_off);
        {la, sa} = a;
        tick(2);
        cmd_n[b] = 1'h0;
        tick(6);
        last_rd = sd_rd;
        chk("outputs during command", e_on, outs);
        cmd_n[b] = 1'h1;
        tick(6);
        chk("outputs after command", e_off, outs);
    endtask

    task automatic complete_run();
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_reset();
        chk("outputs in reset", 8'h7E, outs);
    endtask

    task automatic s_kbc();
        op(`XBSEL_CMD_IOR, 24'h000060, 8'h1A, 8'h7E);
        chk("keyboard data", 8'hA5, last_rd);
        op(`XBSEL_CMD_IOR, 24'h000064, 8'h1A, 8'h7E);
        op(`XBSEL_CMD_IOW, 24'h000064, 8'h5A, 8'h7E);
        op(`XBSEL_CMD_IOR, 24'h000062, 8'h3E, 8'h7E);
        en = 4'h5;
        op(`XBSEL_CMD_IOR, 24'h000060, 8'h3A, 8'h7E);
        en = 4'h7;
    endtask

    task automatic s_rtc();
        int n;
        int m;
        {la, sa} = 24'h000070;
        sd_wr = 8'h2C;
        tick(2);
        cmd_n[`XBSEL_CMD_IOW] = 1'h0;
        n = 0;
        while (ale !== 1'h1 && n < 10) begin
            tick(1);
            n++;
        end
        chk("latch start delay", 8'h03, 8'(n));
        m = 0;
        while (ale === 1'h1 && m < 100) begin
            tick(1);
            m++;
        end
        samples_checked++;
        // two sysclk periods, less up to one for phase, plus sync lag
        if (m < SYSP || m > 2 * SYSP + 6) begin
            errors++;
            $display("MISMATCH latch length expected %0d to %0d seen %0d", SYSP, 2 * SYSP + 6, m);
        end
        cmd_n[`XBSEL_CMD_IOW] = 1'h1;
        op(`XBSEL_CMD_IOR, 24'h000071, 8'h1C, 8'h7E);
        chk("clock chip data", ~8'h2C, last_rd);
    endtask

    task automatic s_rom();
        op(`XBSEL_CMD_MEMW, 24'hFE0000, 8'h56, 8'h76);
        pci_cycle = 1'h0;
        isa_cycle = 1'h1;
        op(`XBSEL_CMD_MEMR, 24'h0E0000, 8'h16, 8'h56);
        {la, sa} = 24'h100000;
        tick(6);
        chk("outputs after address change", 8'h7E, outs);
        op(`XBSEL_CMD_MEMR, 24'h100000, 8'h7E, 8'h7E);
        isa_cycle = 1'h0;
        pci_cycle = 1'h1;
    endtask

    task automatic s_dma();
        aen = 1'h1;
        op(`XBSEL_CMD_IOR, 24'h0E0060, 8'h7E, 8'h7E);
        dma_rd = 1'h1;
        dack_n = 1'h0;
        tick(6);
        chk("outputs in dma read", 8'h3E, outs);
        dack_n = 1'h1;
        tick(6);
        chk("outputs after dma read", 8'h7E, outs);
        {la, sa} = 24'h000000;
        dma_rd = 1'h0;
        aen = 1'h0;
        tick(2);
    endtask

    task automatic s_prg();
        prg = 18'h00300; // 4-byte range at 300h
        sub_isa = 1'h1;
        op(`XBSEL_CMD_IOR, 24'h000302, 8'h0E, 8'h7E);
        op(`XBSEL_CMD_IOR, 24'h000304, 8'h3E, 8'h7E);
        sub_isa = 1'h0;
        prg = 18'h30000;
    endtask

    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        tick(5);
        s_reset();
        reset_n = 1'h1;
        tick(4);
        s_kbc();
        s_rtc();
        s_rom();
        s_dma();
        s_prg();
        complete_run();
    end

    // the whole sequence needs well under 1000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            complete_run();
        end
    end
endmodule
`default_nettype wire
